// file: inc/mlw_pkg.sv
package mlw_pkg;

	localparam int unsigned NUM_VEC    = 10;
	localparam int unsigned NUM_SRC    = 14;
	localparam int unsigned NUM_EXT    = 4;
	localparam int unsigned VEC_ADDR_W = 17;

	// vector address = base + step * index
	localparam logic [VEC_ADDR_W-1:0] VEC_BASE = 17'h00003;
	localparam logic [VEC_ADDR_W-1:0] VEC_STEP = 17'h00008;

	// service levels, ordered highest above high above low
	typedef enum logic [1:0] {
		MLW_LVL_NONE    = 2'h0,
		MLW_LVL_LOW     = 2'h1,
		MLW_LVL_HIGH    = 2'h2,
		MLW_LVL_HIGHEST = 2'h3
	} mlw_lvl_e;

	// vectors below this index choose highest instead of high
	localparam int unsigned NUM_XVEC = 2;

	// source index to vector index
	typedef logic [3:0] mlw_vidx_t;
	localparam mlw_vidx_t SRC_TO_VEC [NUM_SRC] = '{
		4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4,
		4'h5, 4'h5, 4'h7, 4'h7, 4'h8, 4'h9, 4'h9
	};

	// register byte offsets
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_MASK    = 8'h04;
	localparam logic [7:0] REG_LEVEL   = 8'h08;
	localparam logic [7:0] REG_EXTMODE = 8'h0C;
	localparam logic [7:0] REG_STANDBY = 8'h10;
	localparam logic [7:0] REG_SERVICE = 8'h14;

	// reset values
	localparam logic [NUM_VEC-1:0] MASK_RST    = 10'h000;
	localparam logic [NUM_VEC-1:0] LEVEL_RST   = 10'h000;
	localparam logic [NUM_EXT-1:0] EXTMODE_RST = 4'h0;

	// standby register write codes, bits 1:0
	localparam logic [1:0] SBY_CMD_HALT = 2'h1;
	localparam logic [1:0] SBY_CMD_HOLD = 2'h2;

	// number of ext inputs able to end deep sleep, and how many need level mode
	localparam int unsigned NUM_HOLD_WAKE = 3;
	localparam int unsigned NUM_HOLD_LVL  = 2;

	typedef enum logic [1:0] {
		MLW_SBY_RUN  = 2'b00,
		MLW_SBY_HALT = 2'b01,
		MLW_SBY_HOLD = 2'b11
	} mlw_sby_e;

	function automatic mlw_lvl_e mlw_vec_level(input int unsigned idx, input logic cfg);
		if (!cfg)
			return MLW_LVL_LOW;
		else if (idx < NUM_XVEC)
			return MLW_LVL_HIGHEST;
		else
			return MLW_LVL_HIGH;
	endfunction

endpackage

// file: inc/mlw_arb_if.sv
`timescale 1ns/1ps
interface mlw_arb_if;
	import mlw_pkg::*;

	logic [NUM_VEC-1:0] req;
	logic [NUM_VEC-1:0] lvl_cfg;
	mlw_lvl_e           cur_lvl;
	logic               grant;
	mlw_vidx_t          gvec;
	mlw_lvl_e           glvl;

	modport arb (input req, input lvl_cfg, input cur_lvl, output grant, output gvec, output glvl);
	modport ctl (output req, output lvl_cfg, output cur_lvl, input grant, input gvec, input glvl);
endinterface

// file: verilog/mlw_arbiter.sv
`timescale 1ns/1ps
module mlw_arbiter
	import mlw_pkg::*;
(
	mlw_arb_if.arb a
);

	always_comb
	begin
		mlw_lvl_e  best_lvl;
		mlw_vidx_t best_idx;
		mlw_lvl_e  lv;
		best_lvl = MLW_LVL_NONE;
		best_idx = 4'h0;
		lv       = MLW_LVL_NONE;
		// walk downward so equal levels end on the smallest vector
		for (int i = NUM_VEC - 1; i >= 0; i--)
		begin
			lv = mlw_vec_level(i, a.lvl_cfg[i]);
			if (a.req[i] && (lv > a.cur_lvl) && (lv >= best_lvl))
			begin
				best_lvl = lv;
				best_idx = mlw_vidx_t'(i);
			end
		end
		a.grant = (best_lvl != MLW_LVL_NONE);
		a.gvec  = best_idx;
		a.glvl  = best_lvl;
	end

endmodule // mlw_arbiter

// file: verilog/mlw_irq_ctrl.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module mlw_irq_ctrl
	import mlw_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [NUM_EXT-1:0]    ext_irq_i,
	input  wire logic [NUM_SRC-1:0]    periph_irq_i,
	input  wire logic                  rst_pin_n_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  irq_ack_i,
	input  wire logic                  irq_ret_i,
	output logic                       irq_req_o,
	output logic [VEC_ADDR_W-1:0]      irq_vec_o,
	output logic [1:0]                 irq_lvl_o,
	output logic                       irq_o,
	output logic                       cpu_run_o,
	output logic                       periph_run_o,
	output logic                       rc_osc_en_o
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [NUM_EXT-1:0] ext_s1_reg;
	logic [NUM_EXT-1:0] ext_s2_reg;
	logic [NUM_EXT-1:0] ext_d_reg;
	logic               rpin_s1_reg;
	logic               rpin_s2_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_s1_reg  <= 4'h0;
			ext_s2_reg  <= 4'h0;
			ext_d_reg   <= 4'h0;
			rpin_s1_reg <= 1'h1;
			rpin_s2_reg <= 1'h1;
		end
		else
		begin
			ext_s1_reg  <= ext_irq_i;
			ext_s2_reg  <= ext_s1_reg;
			ext_d_reg   <= ext_s2_reg;
			rpin_s1_reg <= rst_pin_n_i;
			rpin_s2_reg <= rpin_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [NUM_VEC-1:0] status_reg;
	logic [NUM_VEC-1:0] mask_reg;
	logic [NUM_VEC-1:0] level_reg;
	logic [NUM_EXT-1:0] extmode_reg;
	mlw_sby_e           sby_reg;
	mlw_sby_e           sby_next;
	logic [2:0]         insvc_reg;
	mlw_lvl_e           cur_lvl;
	logic               wb_hit;
	logic               wb_wr;
	logic [31:0]        wmask;
	logic [31:0]        wdat;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_hit && wb_we_i;
	assign wmask  = {16'h0000, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat   = wb_dat_i & wmask;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_hit;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (wb_hit && !wb_we_i)
		begin
			unique case (wb_adr_i)
				REG_STATUS:  wb_dat_o <= 32'(status_reg);
				REG_MASK:    wb_dat_o <= 32'(mask_reg);
				REG_LEVEL:   wb_dat_o <= 32'(level_reg);
				REG_EXTMODE: wb_dat_o <= 32'(extmode_reg);
				REG_STANDBY: wb_dat_o <= 32'(sby_reg);
				REG_SERVICE: wb_dat_o <= {27'h0000000, insvc_reg, cur_lvl};
				default:     wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_reg    <= MASK_RST;
			level_reg   <= LEVEL_RST;
			extmode_reg <= EXTMODE_RST;
		end
		else if (wb_wr)
		begin
			if (wb_adr_i == REG_MASK)
				mask_reg <= (mask_reg & ~wmask[NUM_VEC-1:0]) | wdat[NUM_VEC-1:0];
			if (wb_adr_i == REG_LEVEL)
				level_reg <= (level_reg & ~wmask[NUM_VEC-1:0]) | wdat[NUM_VEC-1:0];
			if (wb_adr_i == REG_EXTMODE)
				extmode_reg <= (extmode_reg & ~wmask[NUM_EXT-1:0]) | wdat[NUM_EXT-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// source events and sticky status
	logic [NUM_EXT-1:0] ext_evt;
	logic [NUM_SRC-1:0] src_evt;
	logic [NUM_VEC-1:0] vec_set;
	logic [NUM_VEC-1:0] vec_clr;

	// extmode bit high selects level detection, else rising edge
	assign ext_evt = (extmode_reg & ext_s2_reg) | (~extmode_reg & ext_s2_reg & ~ext_d_reg);

	// ext inputs share sources 0,1,2,4 with the peripherals
	always_comb
	begin
		src_evt    = periph_irq_i;
		src_evt[0] = periph_irq_i[0] | ext_evt[0];
		src_evt[1] = periph_irq_i[1] | ext_evt[1];
		src_evt[2] = periph_irq_i[2] | ext_evt[2];
		src_evt[4] = periph_irq_i[4] | ext_evt[3];
	end

	always_comb
	begin
		vec_set = '0;
		for (int s = 0; s < NUM_SRC; s++)
			vec_set[SRC_TO_VEC[s]] = vec_set[SRC_TO_VEC[s]] | src_evt[s];
	end

	assign vec_clr = (wb_wr && wb_adr_i == REG_STATUS) ? wdat[NUM_VEC-1:0] : '0;

	// a new event in the clearing cycle survives
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_reg <= '0;
		else
			status_reg <= (status_reg & ~vec_clr) | vec_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(((status_reg & ~vec_clr) | vec_set) & mask_reg);
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration and nesting
	mlw_arb_if arb_bus ();
	mlw_lvl_e  taken_lvl;
	logic      take;

	// in-service bit n stands for level n+1; the top one is the current level
	always_comb
	begin
		if (insvc_reg[2])
			cur_lvl = MLW_LVL_HIGHEST;
		else if (insvc_reg[1])
			cur_lvl = MLW_LVL_HIGH;
		else if (insvc_reg[0])
			cur_lvl = MLW_LVL_LOW;
		else
			cur_lvl = MLW_LVL_NONE;
	end

	assign arb_bus.req     = status_reg & mask_reg;
	assign arb_bus.lvl_cfg = level_reg;
	assign arb_bus.cur_lvl = cur_lvl;

	mlw_arbiter u_arb (
		.a (arb_bus.arb)
	);
	gvec_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_bus.grant |-> arb_bus.gvec < 4'hA)
		else $error("granted vector out of range");

	assign taken_lvl = mlw_lvl_e'(irq_lvl_o);
	assign take      = irq_ack_i && irq_req_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			insvc_reg <= 3'h0;
		else if (take)
			insvc_reg[taken_lvl - 2'h1] <= 1'b1;
		else if (irq_ret_i)
		begin
			if (insvc_reg[2])
				insvc_reg[2] <= 1'b0;
			else if (insvc_reg[1])
				insvc_reg[1] <= 1'b0;
			else
				insvc_reg[0] <= 1'b0;
		end
	end

	// request dropped in the taking cycle so a stale grant is never offered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_req_o <= 1'b0;
			irq_vec_o <= '0;
			irq_lvl_o <= 2'h0;
		end
		else
		begin
			irq_req_o <= arb_bus.grant && !take && !irq_ret_i && sby_next != MLW_SBY_HOLD;
			irq_vec_o <= VEC_BASE + VEC_ADDR_W'(arb_bus.gvec) * VEC_STEP;
			irq_lvl_o <= arb_bus.glvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// standby
	logic hw_wake;
	logic hold_wake;
	logic [NUM_HOLD_WAKE-1:0] hold_src;

	assign hw_wake = !rpin_s2_reg || sys_rst_i;

	// edge-configured inputs a and b cannot end deep sleep
	assign hold_src  = ext_s2_reg[NUM_HOLD_WAKE-1:0]
		& {1'b1, extmode_reg[NUM_HOLD_LVL-1:0]};
	assign hold_wake = |hold_src;

	always_comb
	begin
		sby_next = sby_reg;
		unique case (sby_reg)
			MLW_SBY_RUN:
			begin
				if (wb_wr && wb_adr_i == REG_STANDBY && wdat[1:0] == SBY_CMD_HALT)
					sby_next = MLW_SBY_HALT;
				else if (wb_wr && wb_adr_i == REG_STANDBY && wdat[1:0] == SBY_CMD_HOLD)
					sby_next = MLW_SBY_HOLD;
			end
			MLW_SBY_HALT:
			begin
				if (hw_wake || arb_bus.grant)
					sby_next = MLW_SBY_RUN;
			end
			MLW_SBY_HOLD:
			begin
				if (hw_wake || hold_wake)
					sby_next = MLW_SBY_RUN;
			end
			default: sby_next = MLW_SBY_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sby_reg <= MLW_SBY_RUN;
		else
			sby_reg <= sby_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cpu_run_o    <= 1'b1;
			periph_run_o <= 1'b1;
			rc_osc_en_o  <= 1'b1;
		end
		else
		begin
			cpu_run_o    <= (sby_next == MLW_SBY_RUN);
			periph_run_o <= (sby_next != MLW_SBY_HOLD);
			rc_osc_en_o  <= (sby_next != MLW_SBY_HOLD);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_taken;
		irq_req_o && irq_ack_i;
	endsequence

	sequence s_returned;
		irq_ret_i && !irq_req_o;
	endsequence

	no_equal_grant_a: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> (irq_lvl_o > $past(cur_lvl)))
		else $error("request offered at or below service level");

	level_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_bus.grant |-> (arb_bus.glvl == mlw_vec_level(32'(arb_bus.gvec), level_reg[arb_bus.gvec])))
		else $error("granted level does not match configuration");

	top_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_bus.grant && (arb_bus.req & level_reg & 10'h003) != 10'h000 && cur_lvl < MLW_LVL_HIGHEST
		|-> arb_bus.glvl == MLW_LVL_HIGHEST)
		else $error("highest level request not preferred");

	low_vector_a: assert property (@(posedge clk_i) disable iff (rst_i)
		arb_bus.grant && arb_bus.req[0] && arb_bus.glvl == mlw_vec_level(0, level_reg[0])
		|-> arb_bus.gvec == 4'h0)
		else $error("smallest vector not preferred");

	nest_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_taken |=> cur_lvl == $past(taken_lvl) ##1 !irq_req_o || irq_lvl_o > $past(taken_lvl, 2))
		else $error("service level not raised on grant");

	nest_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_returned and (!irq_ack_i && insvc_reg != 3'h0)) |=> cur_lvl < $past(cur_lvl))
		else $error("service level not restored on return");

	halt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sby_reg == MLW_SBY_HALT && (arb_bus.grant || sys_rst_i) |=> cpu_run_o)
		else $error("idle standby not left");

	halt_periph_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sby_reg == MLW_SBY_HALT |-> periph_run_o && rc_osc_en_o && !cpu_run_o)
		else $error("idle standby state outputs wrong");

	hold_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sby_reg == MLW_SBY_HOLD |-> !periph_run_o && !rc_osc_en_o && !cpu_run_o)
		else $error("deep sleep state outputs wrong");

	hold_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sby_reg == MLW_SBY_HOLD && !hw_wake && !ext_s2_reg[2] && extmode_reg[1:0] == 2'h0
		|=> sby_reg == MLW_SBY_HOLD)
		else $error("edge input ended deep sleep");

	hold_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sby_reg == MLW_SBY_HOLD && ext_s2_reg[2] |=> sby_reg == MLW_SBY_RUN ##1 cpu_run_o)
		else $error("deep sleep not left on ext input c");

endmodule // mlw_irq_ctrl

// file: sim/mlw_core_model.sv
`timescale 1ns/1ps
module mlw_core_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       irq_req_i,
	input  wire logic       auto_i,
	input  wire logic [3:0] dly_i,
	input  wire logic       ret_req_i,
	output logic            irq_ack_o,
	output logic            irq_ret_o
);
	logic [3:0] wait_reg;

	// ack only while a request stands, never beside a return
	always_ff @(posedge clk_i)
	begin
		irq_ack_o <= 1'b0;
		irq_ret_o <= 1'b0;
		if (rst_i)
			wait_reg <= 4'h0;
		else if (irq_req_i && auto_i && !irq_ack_o && !ret_req_i)
		begin
			wait_reg <= wait_reg + 4'h1;
			if (wait_reg == dly_i)
			begin
				irq_ack_o <= 1'b1;
				wait_reg  <= 4'h0;
			end
		end
		else
		begin
			wait_reg  <= 4'h0;
			irq_ret_o <= ret_req_i;
		end
	end
endmodule // mlw_core_model

// file: sim/multilevel_irq_and_standby_wake_tb.sv
`timescale 1ns/1ps
module multilevel_irq_and_standby_wake_tb
	import mlw_pkg::*;
;
	logic                  clk_i    = 1'b0;
	logic                  rst_i    = 1'b1;
	logic                  wb_cyc   = 1'b0;
	logic                  wb_we    = 1'b0;
	logic [7:0]            wb_adr   = 8'h00;
	logic [31:0]           wb_wdat  = 32'h0;
	logic [31:0]           wb_rdat;
	logic                  wb_ack;
	logic [NUM_EXT-1:0]    ext_irq  = '0;
	logic [NUM_SRC-1:0]    src      = '0;
	logic                  pin_n    = 1'b1;
	logic                  sys_rst  = 1'b0;
	logic                  auto_ack = 1'b0;
	logic [3:0]            dly      = 4'h0;
	logic                  ret_req  = 1'b0;
	logic                  ack;
	logic                  ret;
	logic                  req;
	logic [VEC_ADDR_W-1:0] vec;
	logic [1:0]            lvl;
	logic                  irq;
	logic                  cpu_run;
	logic                  per_run;
	logic                  osc_en;
	logic [31:0]           rd;
	logic [9:0]            lc;
	logic [9:0]            pv;
	logic [NUM_SRC-1:0]    ps;
	int                    failures        = 0;
	int                    samples_checked = 0;
	localparam logic [7:0] RST_ADR [7] = '{REG_STATUS, REG_MASK, REG_LEVEL, REG_EXTMODE, REG_STANDBY,
		REG_SERVICE, 8'h20};

	always #2.5 clk_i = ~clk_i;

	mlw_irq_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.ext_irq_i(ext_irq), .periph_irq_i(src), .rst_pin_n_i(pin_n), .sys_rst_i(sys_rst), .irq_ack_i(ack),
		.irq_ret_i(ret), .irq_req_o(req), .irq_vec_o(vec), .irq_lvl_o(lvl), .irq_o(irq),
		.cpu_run_o(cpu_run), .periph_run_o(per_run), .rc_osc_en_o(osc_en));

	mlw_core_model core (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(req), .auto_i(auto_ack), .dly_i(dly),
		.ret_req_i(ret_req), .irq_ack_o(ack), .irq_ret_o(ret));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pin(input logic [19:0] got, input logic [19:0] exp);
		cmp_reg({12'h0, got}, {12'h0, exp});
	endtask

	task automatic end_of_test;
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// request held until the edge that samples ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 20);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		if (n >= 20)
			failures++;
	endtask

	task automatic pulse(input int s);
		@(posedge clk_i);
		src[s] <= 1'b1;
		@(posedge clk_i);
		src[s] <= 1'b0;
	endtask

	task automatic do_ret;
		@(posedge clk_i);
		ret_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		tick(3);
	endtask

	task automatic wait_run;
		int n;
		for (n = 0; n < 40 && cpu_run !== 1'b1; n++)
			@(posedge clk_i);
		cmp_pin(20'(cpu_run), 20'h1);
	endtask

	function automatic logic [18:0] arb_exp(input logic [9:0] p, input logic [9:0] c);
		logic [1:0] best;
		logic [1:0] l;
		int         bi;
		best = 2'h0;
		bi   = 0;
		for (int i = 0; i < NUM_VEC; i++)
		begin
			l = !c[i] ? 2'h1 : (i < NUM_XVEC ? 2'h3 : 2'h2);
			// strict compare keeps the smallest vector on a tie
			if (p[i] && l > best)
			begin
				best = l;
				bi   = i;
			end
		end
		return {best, 17'(VEC_BASE + VEC_STEP * bi)};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		failures++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(32'h82d060d0));
		tick(3);
		rst_i <= 1'b0;
		cmp_pin(20'({cpu_run, per_run, osc_en}), 20'h7);
		foreach (RST_ADR[i])
		begin
			wb(1'b0, RST_ADR[i], 32'h0);
			cmp_reg(rd, 32'h0);
		end
		wb(1'b1, REG_MASK, 32'h3FF);
		for (int i = 0; i < 12; i++)
		begin
			lc = (i == 0) ? 10'h3FF : 10'($urandom);
			ps = (i == 0) ? 14'h3FFF : 14'($urandom) | 14'h1000;
			wb(1'b1, REG_LEVEL, {22'h0, lc});
			@(posedge clk_i);
			src <= ps;
			@(posedge clk_i);
			src <= '0;
			pv = '0;
			for (int s = 0; s < NUM_SRC; s++)
				if (ps[s])
					pv[SRC_TO_VEC[s]] = 1'b1;
			tick(3);
			cmp_pin({req, lvl, vec}, {1'b1, arb_exp(pv, lc)});
			wb(1'b1, REG_STATUS, 32'h3FF);
			tick(2);
			cmp_pin(20'(req), 20'h0);
		end
		// nesting: low in service, then highest on top
		wb(1'b1, REG_LEVEL, 32'h1);
		dly      <= 4'($urandom % 4);
		auto_ack <= 1'b1;
		pulse(4);
		tick(12);
		wb(1'b0, REG_SERVICE, 32'h0);
		cmp_reg(32'(rd[1:0]), 32'h1);
		pulse(9);
		tick(6);
		cmp_pin(20'(req), 20'h0);
		auto_ack <= 1'b0;
		pulse(0);
		tick(3);
		cmp_pin({req, lvl, vec}, {1'b1, 2'h3, 17'h00003});
		auto_ack <= 1'b1;
		tick(12);
		wb(1'b0, REG_SERVICE, 32'h0);
		cmp_reg(32'(rd[1:0]), 32'h3);
		auto_ack <= 1'b0;
		wb(1'b1, REG_STATUS, 32'h3FF);
		do_ret();
		wb(1'b0, REG_SERVICE, 32'h0);
		cmp_reg(32'(rd[1:0]), 32'h1);
		do_ret();
		wb(1'b0, REG_SERVICE, 32'h0);
		cmp_reg(32'(rd[1:0]), 32'h0);
		// sticky status, mask, level output
		wb(1'b1, REG_MASK, 32'h0);
		pulse(12);
		tick(3);
		cmp_pin(20'(irq), 20'h0);
		wb(1'b0, REG_STATUS, 32'h0);
		cmp_reg(rd, 32'h200);
		wb(1'b1, REG_MASK, 32'h200);
		tick(2);
		cmp_pin(20'(irq), 20'h1);
		wb(1'b1, REG_STATUS, 32'h200);
		tick(2);
		cmp_pin(20'(irq), 20'h0);
		// idle standby
		wb(1'b1, REG_MASK, 32'h3FF);
		wb(1'b1, REG_STANDBY, 32'h1);
		tick(2);
		cmp_pin(20'({cpu_run, per_run, osc_en}), 20'h3);
		pulse(11);
		wait_run();
		wb(1'b1, REG_STATUS, 32'h3FF);
		wb(1'b1, REG_STANDBY, 32'h1);
		tick(2);
		cmp_pin(20'(cpu_run), 20'h0);
		sys_rst <= 1'b1;
		tick(1);
		sys_rst <= 1'b0;
		wait_run();
		wb(1'b1, REG_STANDBY, 32'h1);
		tick(2);
		cmp_pin(20'(cpu_run), 20'h0);
		pin_n <= 1'b0;
		wait_run();
		pin_n <= 1'b1;
		// deep sleep; edge-mode ext a must not wake
		wb(1'b1, REG_MASK, 32'h0);
		wb(1'b1, REG_STANDBY, 32'h2);
		tick(2);
		cmp_pin(20'({cpu_run, per_run, osc_en}), 20'h0);
		ext_irq[0] <= 1'b1;
		tick(10);
		cmp_pin(20'(cpu_run), 20'h0);
		ext_irq <= 4'h4;
		wait_run();
		ext_irq <= 4'h0;
		wb(1'b1, REG_STANDBY, 32'h2);
		tick(2);
		cmp_pin(20'(cpu_run), 20'h0);
		pin_n <= 1'b0;
		wait_run();
		pin_n <= 1'b1;
		wb(1'b1, REG_EXTMODE, 32'h1);
		wb(1'b1, REG_STANDBY, 32'h2);
		tick(2);
		cmp_pin(20'(cpu_run), 20'h0);
		ext_irq[0] <= 1'b1;
		wait_run();
		ext_irq <= 4'h0;
		tick(2);
		end_of_test();
	end
endmodule // multilevel_irq_and_standby_wake_tb
